// [core/driver_serial_control_port.sv]
// Serial control and diagnostic port of the five-output load driver
// Functional notes
// - Sixteen-bit control word, bit 0 shifted first.
// - Chip select is active low; no transfer while it is high.
// - Serial output is released whenever chip select is high.
// - Shift register advances only on the host serial clock.
// - Enable low means standby: outputs off, control and status registers cleared.
// - Control bits 9 to 11 pick the current shown on monitor pin.
// - Monitor pin is two-way; host may overdrive it as PWM gate.
// - Output modes forward, reverse, brake, float set only by control words.
// - All diagnosis readable over the serial output.
// - Open-load and overload reported separately for each of five outputs.
// - Three outputs source, sink or float; two are high-side only.
// - Programmable soft start lets high-inrush loads switch on.
// - Open load must persist a qualification time before its bit sets.
module driver_serial_control_port
  import drv_port_pkg::*;
#(
  parameter int unsigned OL_CYCLES   = 62500,
  parameter int unsigned SOFT_CYCLES = 1250
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       enable_in,
  input  wire logic       serial_clk,
  input  wire logic       select_low_in,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_en,
  input  wire logic       monitor_pwm_pin_in,
  output logic            monitor_pwm_pin_out,
  output logic            monitor_pwm_pin_en,
  output logic [2:0]      monitor_sel,
  input  wire logic [4:0] open_load_raw,
  input  wire logic [4:0] overload_raw,
  output logic [2:0]      bridge_high_on,
  output logic [2:0]      bridge_low_on,
  output logic [1:0]      highside_on,
  output logic            standby
);
  `include "drv_port_defs.svh"

  // *****************************************************************
  // Input synchronisers
  // *****************************************************************
  logic [2:0] en_s_q;
  logic [2:0] pwm_s_q;
  logic [2:0] tog_s_q;
  logic [4:0] ol_s1_q, ol_s2_q, ol_s3_q;
  logic [4:0] ov_s1_q, ov_s2_q, ov_s3_q;
  logic       en_lvl_q;
  logic       pwm_lvl_q;
  logic       tog_lvl_q;
  logic [2:0] sel_s_q;
  frame_if    frm ();

  // Three stages each; a level counts once the second and third agree
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_s_q  <= 3'h0;
      pwm_s_q <= 3'h7; // Matches the idle level below, so no false low
      tog_s_q <= 3'h0;
      sel_s_q <= 3'h7;
      ol_s1_q <= 5'h00;
      ol_s2_q <= 5'h00;
      ol_s3_q <= 5'h00;
      ov_s1_q <= 5'h00;
      ov_s2_q <= 5'h00;
      ov_s3_q <= 5'h00;
    end else begin
      en_s_q  <= {en_s_q[1:0], enable_in};
      pwm_s_q <= {pwm_s_q[1:0], monitor_pwm_pin_in};
      tog_s_q <= {tog_s_q[1:0], frm.toggle};
      sel_s_q <= {sel_s_q[1:0], select_low_in};
      ol_s1_q <= open_load_raw;
      ol_s2_q <= ol_s1_q;
      ol_s3_q <= ol_s2_q;
      ov_s1_q <= overload_raw;
      ov_s2_q <= ov_s1_q;
      ov_s3_q <= ov_s2_q;
    end
  end

  // Agreement filter for the three levels: enable, PWM and toggle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_lvl_q  <= 1'b0;
      pwm_lvl_q <= 1'b1;
      tog_lvl_q <= 1'b0;
    end else begin
      if (en_s_q[2] == en_s_q[1]) begin
        en_lvl_q <= en_s_q[2];
      end
      if (pwm_s_q[2] == pwm_s_q[1]) begin
        pwm_lvl_q <= pwm_s_q[2];
      end
      if (tog_s_q[2] == tog_s_q[1]) begin
        tog_lvl_q <= tog_s_q[2];
      end
    end
  end

  // *****************************************************************
  // Link-side logic on the host clock
  // *****************************************************************
  logic [15:0] status_q;

  serial_link u_link (
    .serial_clk    (serial_clk),
    .reset_n       (reset_n),
    .select_low_in (select_low_in),
    .serial_in     (serial_in),
    .status_word   (status_q),
    .serial_out    (serial_out),
    .serial_out_en (serial_out_en),
    .frm           (frm)
  );

  // *****************************************************************
  // Control register in the core domain
  // *****************************************************************
  logic [15:0] ctrl_q;
  logic        new_word;
  // A toggle counts once two stages agree on a level new to the filter
  assign new_word = (tog_s_q[2] == tog_s_q[1]) && (tog_s_q[2] != tog_lvl_q);

  // Word is stable for many core cycles once its toggle is seen
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `CTRL_RESET;
    end else if (!en_lvl_q) begin
      ctrl_q <= `CTRL_RESET;
    end else if (new_word) begin
      ctrl_q <= frm.word;
    end
  end

  assign standby = ~en_lvl_q;

  // *****************************************************************
  // Mode decode and output gating
  // *****************************************************************
  // Shared decode for all three half bridges
  function automatic logic [1:0] bridge_drive(input logic [1:0] m);
    unique case (bridge_mode_t'(m))
      MODE_FORWARD: bridge_drive = 2'h2;
      MODE_REVERSE: bridge_drive = 2'h1;
      MODE_BRAKE:   bridge_drive = 2'h1;
      MODE_FLOAT:   bridge_drive = 2'h0;
    endcase
  endfunction : bridge_drive

  logic [1:0] drv_a, drv_b, drv_c;
  logic       gate;
  logic       soft_gate;
  assign drv_a = bridge_drive(ctrl_q[`MODE_A_LSB +: 2]);
  assign drv_b = bridge_drive(ctrl_q[`MODE_B_LSB +: 2]);
  assign drv_c = bridge_drive(ctrl_q[`MODE_C_LSB +: 2]);

  // With PWM enabled the host level on the pin gates every output
  assign gate = (!ctrl_q[`PWM_EN_BIT] || pwm_lvl_q) && soft_gate;

  // Outputs registered, so data outputs come from flip-flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_high_on <= 3'h0;
      bridge_low_on  <= 3'h0;
      highside_on    <= 2'h0;
    end else if (!en_lvl_q) begin
      bridge_high_on <= 3'h0;
      bridge_low_on  <= 3'h0;
      highside_on    <= 2'h0;
    end else begin
      bridge_high_on <= {drv_c[1], drv_b[1], drv_a[1]} & {3{gate}};
      bridge_low_on  <= {drv_c[0], drv_b[0], drv_a[0]} & {3{gate}};
      highside_on    <= {ctrl_q[`HS_B_BIT], ctrl_q[`HS_A_BIT]} & {2{gate}};
    end
  end

  // *****************************************************************
  // Soft start: outputs pulse for a programmable time after any change
  // *****************************************************************
  // Chopping the drive limits inrush beyond the current limit
  logic [15:0] soft_cnt_q;
  logic [2:0]  soft_steps_q;
  logic [15:0] prev_ctrl_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_cnt_q   <= 16'h0000;
      soft_steps_q <= 3'h0;
      prev_ctrl_q  <= 16'h0000;
    end else begin
      prev_ctrl_q <= ctrl_q;
      if (ctrl_q != prev_ctrl_q && ctrl_q[`SOFT_EN_BIT]) begin
        soft_steps_q <= ctrl_q[`SOFT_SEL_MSB:`SOFT_SEL_LSB];
        soft_cnt_q   <= 16'h0000;
      end else if (soft_steps_q != 3'h0) begin
        if (soft_cnt_q == 16'(SOFT_CYCLES - 1)) begin
          soft_cnt_q   <= 16'h0000;
          soft_steps_q <= soft_steps_q - 3'h1;
        end else begin
          soft_cnt_q <= soft_cnt_q + 16'h0001;
        end
      end
    end
  end
  // Half duty while ramping
  assign soft_gate = (soft_steps_q == 3'h0) || soft_cnt_q[3];

  // *****************************************************************
  // Monitor select and pin drive
  // *****************************************************************
  assign monitor_sel = ctrl_q[`MUX_MSB:`MUX_LSB];
  // Released when PWM input is in use so the host can drive the pin
  assign monitor_pwm_pin_en  = en_lvl_q && !ctrl_q[`PWM_EN_BIT]
                               && (monitor_sel != 3'(MON_NONE));
  assign monitor_pwm_pin_out = 1'b0;

  // *****************************************************************
  // Diagnosis: qualified open load, overload, per output
  // *****************************************************************
  logic [4:0] ol_q;
  genvar gi;
  for (gi = 0; gi < 5; gi++) begin : g_ol
    qual_timer #(.CYCLES(OL_CYCLES)) u_ol (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .cond_in   (ol_s3_q[gi] & ol_s2_q[gi] & en_lvl_q),
      .qualified (ol_q[gi])
    );
  end

  // Status word: bit 0 any fault, open loads, overloads
  // Frozen while selected, since the link copies it across domains;
  // a host must allow a few core cycles after select before bit 0 is read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 16'h0000;
    end else if (!en_lvl_q) begin
      status_q <= 16'h0000;
    end else if (sel_s_q[2] && sel_s_q[1]) begin
      status_q[0]     <= |{ol_q, ov_s3_q & ov_s2_q};
      status_q[5:1]   <= ol_q;
      status_q[10:6]  <= ov_s3_q & ov_s2_q;
      status_q[15:11] <= 5'h00;
    end
  end
endmodule : driver_serial_control_port

// [core/drv_port_defs.svh]
// Constants for the serial control port of the multi-output load driver
`ifndef DRV_PORT_DEFS_SVH
`define DRV_PORT_DEFS_SVH

// Frame length and field positions of the control word
`define FRAME_BITS      16
`define MUX_LSB         9
`define MUX_MSB         11
`define MODE_A_LSB      0
`define MODE_B_LSB      2
`define MODE_C_LSB      4
`define HS_A_BIT        6
`define HS_B_BIT        7
`define PWM_EN_BIT      8
`define SOFT_EN_BIT     12
`define SOFT_SEL_LSB    13
`define SOFT_SEL_MSB    15

// Reset contents of the control register
`define CTRL_RESET      16'h0000

// Open-load qualification time and core clock rate
`define OL_QUAL_US      500
`define CLK_MHZ         125
`define OL_QUAL_CYCLES  (`OL_QUAL_US * `CLK_MHZ)

// Soft start step unit in core cycles
`define SOFT_STEP_CYCLES 1250

`endif

// [core/drv_port_pkg.sv]
// Types shared by the serial control port modules
package drv_port_pkg;

  // Half-bridge operating modes
  typedef enum logic [1:0] {
    MODE_FLOAT   = 2'h0,
    MODE_FORWARD = 2'h1,
    MODE_REVERSE = 2'h2,
    MODE_BRAKE   = 2'h3
  } bridge_mode_t;

  // Monitor multiplexer choices
  typedef enum logic [2:0] {
    MON_NONE  = 3'h0,
    MON_OUT_A = 3'h1,
    MON_OUT_B = 3'h2,
    MON_OUT_C = 3'h3,
    MON_HS_A  = 3'h4,
    MON_HS_B  = 3'h5
  } mon_sel_t;

endpackage : drv_port_pkg

// [core/frame_if.sv]
// Carrier of a received control word from the link domain to the core domain
interface frame_if;
  logic        toggle;
  logic [15:0] word;

  modport link (output toggle, output word);
  modport core (input toggle, input word);
endinterface : frame_if

// [core/serial_link.sv]
// Serial shift logic clocked by the host serial clock
module serial_link (
  input  wire logic        serial_clk,
  input  wire logic        reset_n,
  input  wire logic        select_low_in,
  input  wire logic        serial_in,
  input  wire logic [15:0] status_word,
  output logic             serial_out,
  output logic             serial_out_en,
  frame_if.link            frm
);
  `include "drv_port_defs.svh"

  logic [15:0] shift_q;
  logic [15:0] tx_q;
  logic [4:0]  count_q;
  logic        tog_q;
  logic [15:0] word_q;
  logic        tx_started_q;

  // *****************************************************************
  // Receive shift, LSB first, only on the host clock
  // *****************************************************************
  // Chip select high resets the frame, so a partial frame never survives
  always_ff @(posedge serial_clk or posedge select_low_in) begin
    if (select_low_in) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
    end else begin
      shift_q <= {serial_in, shift_q[15:1]};
      if (count_q != 5'h1F) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  // *****************************************************************
  // Transmit shift of status, LSB first, changing on falling edges
  // *****************************************************************
  // Bit 0 is shown straight from status at select; the first falling edge
  // loads the rest, so the core holds status still while selected
  always_ff @(negedge serial_clk or posedge select_low_in) begin
    if (select_low_in) begin
      tx_q <= 16'h0000;
    end else if (!tx_started_q) begin
      tx_q <= {1'b0, status_word[15:1]};
    end else begin
      tx_q <= {1'b0, tx_q[15:1]};
    end
  end

  // First bit comes straight from status, later ones from the shifter
  always_ff @(negedge serial_clk or posedge select_low_in) begin
    if (select_low_in) begin
      tx_started_q <= 1'b0;
    end else begin
      tx_started_q <= 1'b1;
    end
  end

  // Shifter only loses bit 0 after the first falling edge
  logic [15:0] tx_view;
  assign tx_view    = tx_started_q ? tx_q : status_word;
  assign serial_out = tx_view[0];
  // Driven only while selected, released otherwise
  assign serial_out_en = ~select_low_in;

  // *****************************************************************
  // Frame commit on rising chip select
  // *****************************************************************
  // Word is captured only for exactly sixteen clocks
  // Reset here too, so the toggle and the core's copy of it start equal
  always_ff @(posedge select_low_in or negedge reset_n) begin
    if (!reset_n) begin
      word_q <= 16'h0000;
      tog_q  <= 1'b0;
    end else if (count_q == 5'(`FRAME_BITS)) begin
      word_q <= shift_q;
      tog_q  <= ~tog_q;
    end
  end

  assign frm.toggle = tog_q;
  assign frm.word   = word_q;

endmodule : serial_link

// [core/qual_timer.sv]
// Persistence filter: an input must hold high for a count before it is reported
module qual_timer #(
  parameter int unsigned CYCLES = 62500
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic cond_in,
  output logic      qualified
);
  logic [$clog2(CYCLES+1)-1:0] cnt_q;

  // Counter restarts at any break of the condition
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q     <= '0;
      qualified <= 1'b0;
    end else if (!cond_in) begin
      cnt_q     <= '0;
      qualified <= 1'b0;
    end else if (cnt_q == ($clog2(CYCLES+1))'(CYCLES - 1)) begin
      qualified <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : qual_timer

// [tb/drv_port_checker.sv]
// Assertion checker for the serial control port, bound to its top module
// ********************
// Port checks
// ********************
module drv_port_checker (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       enable_in,
  input wire logic       select_low_in,
  input wire logic       serial_out_en,
  input wire logic       monitor_pwm_pin_en,
  input wire logic [2:0] monitor_sel,
  input wire logic [2:0] bridge_high_on,
  input wire logic [2:0] bridge_low_on,
  input wire logic [1:0] highside_on,
  input wire logic       standby
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic       sel_q;
  logic [5:0] since_q;
  // Cycles since a frame closed or enable dropped; control may move only shortly after
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q   <= 1'b1;
      since_q <= 6'h00;
    end else begin
      sel_q <= select_low_in;
      if ((select_low_in && !sel_q) || !enable_in)
        since_q <= 6'h00;
      else if (since_q != 6'h3F)
        since_q <= since_q + 6'h01;
    end
  end
  sequence enable_low_s; !enable_in [*6]; endsequence
  sequence enable_high_s; enable_in [*6]; endsequence
  sequence cleared_s;
    bridge_high_on == 3'h0 && bridge_low_on == 3'h0 && highside_on == 2'h0 && monitor_sel == 3'h0;
  endsequence
  chk_out_release: assert property (serial_out_en == !select_low_in)
    else $error("serial output enable does not follow chip select");
  chk_leg_exclusive: assert property ((bridge_high_on & bridge_low_on) == 3'h0)
    else $error("both switches of one leg on");
  chk_standby_enter: assert property (enable_low_s |-> standby)
    else $error("no standby while enable held low");
  chk_standby_leave: assert property (enable_high_s |-> !standby)
    else $error("standby while enable held high");
  chk_standby_off: assert property (standby ##1 standby |-> cleared_s)
    else $error("outputs active in standby");
  chk_standby_clear: assert property ($rose(standby) |-> ##[0:3] cleared_s)
    else $error("control not cleared on standby");
  chk_commit_window: assert property ($changed(monitor_sel) |-> since_q <= 6'h0C)
    else $error("monitor select moved outside a frame commit");
  chk_monitor_drive: assert property (monitor_pwm_pin_en |-> monitor_sel != 3'h0)
    else $error("monitor pin driven with no source selected");
endmodule : drv_port_checker

bind driver_serial_control_port drv_port_checker u_chk (
  .ref_clk, .reset_n, .enable_in, .select_low_in, .serial_out_en, .monitor_pwm_pin_en,
  .monitor_sel, .bridge_high_on, .bridge_low_on, .highside_on, .standby
);

// [tb/host_model.sv]
// Host controller model that runs serial frames against the port
// ********************
// Frame master
// ********************
module host_model (
  output logic      serial_clk,
  output logic      select_low_in,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clk    = 1'b0;
    select_low_in = 1'b1;
    serial_in     = 1'b0;
  end
  // Clock runs only inside a frame; odd lengths exist to provoke refusal
  task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    select_low_in = 1'b0;
    serial_in = tx[0];
    #15;
    for (int i = 0; i < nbits; i++) begin
      serial_clk = 1'b1;
      rx[i % 16] = serial_out_en ? serial_out : 1'bx;
      #15;
      serial_clk = 1'b0;
      serial_in = tx[(i + 1) % 16];
      #15;
    end
    select_low_in = 1'b1;
    serial_in = ~serial_in; // Released line shows the inverse, not a stale bit
  endtask : xfer
endmodule : host_model

// [tb/testbench.sv]
// Self-checking bench for the serial control port of the load driver
module testbench
  import drv_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Signals and instances
  // ********************
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        enable_in = 1'b1;
  logic        pwm_lvl = 1'b1;
  logic [4:0]  open_load_raw = 5'h00;
  logic [4:0]  overload_raw = 5'h00;
  logic        serial_clk, select_low_in, serial_in, serial_out, serial_out_en;
  logic        pin_out, pin_en, standby;
  logic [2:0]  monitor_sel, bridge_high_on, bridge_low_on;
  logic [1:0]  highside_on;
  logic [15:0] rx;
  int          fail_count = 0;
  int          cmp_count = 0;
  // Row: control word, then {monitor_sel, highside, low switches, high switches}
  logic [26:0] rows [5] = '{{16'h0279, 11'h171}, {16'h049E, 11'h29C}, {16'h06E7, 11'h3EA},
                            {16'h0800, 11'h400}, {16'h0A15, 11'h507}};
  wire         pin_level = pin_en ? pin_out : pwm_lvl;
  wire [10:0]  outs = {monitor_sel, highside_on, bridge_low_on, bridge_high_on};
  always #4 ref_clk = ~ref_clk;
  driver_serial_control_port #(.OL_CYCLES(20), .SOFT_CYCLES(16)) dut (
    .ref_clk, .reset_n, .enable_in, .serial_clk, .select_low_in, .serial_in, .serial_out,
    .serial_out_en, .monitor_pwm_pin_in(pin_level), .monitor_pwm_pin_out(pin_out),
    .monitor_pwm_pin_en(pin_en), .monitor_sel, .open_load_raw, .overload_raw,
    .bridge_high_on, .bridge_low_on, .highside_on, .standby
  );
  host_model host (.serial_clk, .select_low_in, .serial_in, .serial_out, .serial_out_en);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // One frame, then a settle time covering the crossing and the output register
  task automatic frame(input int nbits, input logic [15:0] w);
    @(posedge ref_clk);
    #1;
    host.xfer(nbits, w, rx);
    repeat (10) @(posedge ref_clk);
    #1;
  endtask : frame
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  // ********************
  // Tests
  // ********************
  initial begin
    idle(5);
    reset_n = 1'b1;
    check(outs, 16'h0000);
    check(serial_out_en, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      frame(16, rows[i][26:11]);
      check(outs, rows[i][10:0]);
      check(pin_en, rows[i][10:8] != 3'h0);
      check(pin_out, 16'h0000);
      check(rx[10:0], 16'h0000);
    end
    $display("test modes done");
    frame(15, 16'h0279);
    frame(17, 16'h0279);
    check(outs, 16'h0507);
    $display("test frame length done");
    frame(16, 16'h0341);
    check(outs, 16'h0141);
    check(pin_en, 16'h0000);
    pwm_lvl = 1'b0;
    idle(8);
    check(outs, 16'h0100);
    pwm_lvl = 1'b1;
    idle(8);
    check(outs, 16'h0141);
    $display("test pwm done");
    open_load_raw = 5'h1F;
    idle(10);
    open_load_raw = 5'h00;
    frame(16, 16'h0000);
    check(rx[5:1], 16'h0000);
    open_load_raw = 5'h05;
    overload_raw = 5'h10;
    idle(40);
    frame(16, 16'h0000);
    check(rx, {5'h00, 5'h10, 5'h05, 1'b1});
    open_load_raw = 5'h00;
    overload_raw = 5'h00;
    $display("test diagnosis done");
    // One soft step: chopped low half of the step at frame end, full on later
    frame(16, 16'h3001);
    check(outs, 16'h0000);
    idle(40);
    check(outs, 16'h0001);
    $display("test soft start done");
    frame(16, 16'h0279);
    enable_in = 1'b0;
    idle(10);
    check(outs, 16'h0000);
    check(standby, 16'h0001);
    frame(16, 16'h0279);
    enable_in = 1'b1;
    idle(10);
    check(outs, 16'h0000);
    check(standby, 16'h0000);
    $display("test standby done");
    // Reset in mid-run clears control; the next frame must still be taken
    frame(16, 16'h0279);
    check(outs, 16'h0171);
    reset_n = 1'b0;
    idle(2);
    check(outs, 16'h0000);
    check(standby, 16'h0001);
    reset_n = 1'b1;
    idle(10);
    check(outs, 16'h0000);
    frame(16, 16'h0279);
    check(outs, 16'h0171);
    $display("test mid-run reset done");
    test_done();
  end
  // Watchdog: the tests need about ten microseconds, so this is ample
  initial begin
    #200us;
    fail_count++;
    test_done();
  end
endmodule : testbench
